// File: verilog/amlt_top.sv
// Address map, write protection and temperature-indexed resistor look-up
// Functional notes
// RULE1: Temperature maps 80h upward, one per 2 degrees
// RULE2: Clamp index to 80h and C7h
// RULE3: Each entry holds two independent 8-bit positions
// RULE4: Index enable low selects manual mode
// RULE5: Manual positions from table 01 82h/83h
// RULE6: Temperature word is signed, 1/256 degree
// RULE7: Supply word unsigned, 100 microvolt unit
// RULE8: Monitor words unsigned, 38.147 microvolt unit
// RULE9: Two-address mode answers A0h and main
// RULE10: Main address from NV byte or A2h
// RULE11: Single-address mode hides aux, adds table 00
// RULE12: Upper locations only through main address
// RULE13: Main 7Fh selects upper table
// RULE14: Aux never reaches tables; maps as table 03
// RULE15: Main protected only when pin and enable high
// RULE16: Aux and table 00 follow aux enable only
// RULE17: Aux space is 128 zeroed NV bytes
// RULE18: Protect pin pulled high when unconnected
// RULE19: Measured words left-justified, 12 significant bits
// RULE20: Index is floor((T+40)/2) plus 80h, clamped
`include "amlt_params.svh"
`timescale 1ns/1ps
module amlt_top
  import amlt_pkg::*;
#(
  parameter int MEM_AW = 10
) (
  input  wire logic       core_clk_i,
  input  wire logic       reset_n_i,
  input  wire amlt_req_t  req_i,
  input  wire amlt_meas_t meas_i,
  input  wire logic       write_protect_pin_i,
  output logic            ack_o,
  output logic            nack_o,
  output logic            rvalid_o,
  output logic [7:0]      rdata_o,
  output logic [7:0]      res0_pos_o,
  output logic [7:0]      res1_pos_o,
  output logic [7:0]      main_addr_o
);
  // ****************************************************************
  // Memory layout: 256-byte banks, bank 0 lower main, 1..3 tables
  // ****************************************************************
  function automatic logic [7:0] lut_index(input logic [15:0] t);
    logic signed [15:0] whole;
    logic signed [15:0] idx;
    whole = 16'(signed'(t[15:8]));
    idx   = (whole + `AMLT_TEMP_OFFSET) >>> 1; // [RULE20] [RULE1]
    if (idx < 16'sd0) begin
      lut_index = `AMLT_LUT_FIRST; // [RULE2]
    end else if (idx > 16'(`AMLT_LUT_LAST - `AMLT_LUT_FIRST)) begin
      lut_index = `AMLT_LUT_LAST; // [RULE2]
    end else begin
      lut_index = 8'(idx) + `AMLT_LUT_FIRST; // [RULE1]
    end
  endfunction : lut_index

  function automatic logic [9:0] mem_addr(input logic [1:0] bank, input logic [7:0] loc);
    mem_addr = {bank, loc};
  endfunction : mem_addr

  // ****************************************************************
  // Configuration and shadow state
  // ****************************************************************
  logic [7:0]  cfg_ff;
  logic [7:0]  tbl_sel_ff;
  logic [7:0]  nv_addr_ff;
  logic [7:0]  man0_ff;
  logic [7:0]  man1_ff;
  logic [15:0] mask_cfg;
  logic        temp_index_enable;
  logic        single_address_enable;
  logic        main_address_from_nv;
  logic        main_protect_enable;
  logic        aux_protect_enable;

  assign temp_index_enable   = cfg_ff[`AMLT_CFG_TEN_BIT];
  assign single_address_enable  = cfg_ff[`AMLT_CFG_SINGLE_ADDRESS_ENABLE_BIT];
  assign main_address_from_nv = cfg_ff[`AMLT_CFG_MAIN_ADDRESS_FROM_NV_BIT];
  assign main_protect_enable  = cfg_ff[`AMLT_CFG_MAIN_PROTECT_ENABLE_BIT];
  assign aux_protect_enable  = cfg_ff[`AMLT_CFG_AUX_PROTECT_ENABLE_BIT];
  assign mask_cfg = `AMLT_MEAS_MASK;

  // Pin pull-up lives in the pad; here high means protect requested
  logic protect_main;
  logic protect_aux;
  assign protect_main = write_protect_pin_i & main_protect_enable; // [RULE15] [RULE18]
  assign protect_aux  = aux_protect_enable; // [RULE16]

  assign main_addr_o = main_address_from_nv ? nv_addr_ff : `AMLT_MAIN_DEV_ADDR; // [RULE10]

  // ****************************************************************
  // Address decode
  // ****************************************************************
  logic       is_main;
  logic       is_aux;
  logic       hit;
  logic [1:0] bank;
  logic       wr_ok;
  logic       tbl_valid;
  logic       meas_hit;

  always_comb begin
    is_main = (req_i.dev_addr == main_addr_o);
    is_aux  = (req_i.dev_addr == `AMLT_AUX_DEV_ADDR) && !single_address_enable; // [RULE9] [RULE11]
    tbl_valid = (tbl_sel_ff == `AMLT_TBL_LUT0) || (tbl_sel_ff == `AMLT_TBL_LUT1) ||
                (tbl_sel_ff == `AMLT_TBL_MAP_AUX) ||
                ((tbl_sel_ff == `AMLT_TBL_AUX) && single_address_enable); // [RULE11]
    meas_hit = 1'b0;
    bank  = 2'h0;
    wr_ok = 1'b0;
    hit   = 1'b0;
    if (is_main && !req_i.loc[7]) begin
      hit   = 1'b1;
      bank  = 2'h0;
      meas_hit = (req_i.loc >= `AMLT_TEMP_LOC) && (req_i.loc <= (`AMLT_MONC_LOC + 8'h01));
      wr_ok = !protect_main && !meas_hit; // [RULE15]
    end else if (is_main && req_i.loc[7] && tbl_valid) begin
      hit  = 1'b1; // [RULE12] [RULE13]
      // Table 00 and mapped aux share the aux bank
      if ((tbl_sel_ff == `AMLT_TBL_AUX) || (tbl_sel_ff == `AMLT_TBL_MAP_AUX)) begin
        bank  = 2'h3; // [RULE14]
        wr_ok = !protect_aux; // [RULE16]
      end else begin
        bank  = tbl_sel_ff[1:0];
        wr_ok = !protect_main;
      end
    end else if (is_aux && !req_i.loc[7]) begin
      // Aux device never sees 80h and up, so those requests fall through to nack
      hit   = 1'b1;
      bank  = 2'h3; // [RULE17] [RULE14]
      wr_ok = !protect_aux; // [RULE16]
    end
  end

  logic do_wr;
  logic [7:0] aux_loc;
  assign aux_loc = {1'b0, req_i.loc[6:0]}; // [RULE12]
  assign do_wr = req_i.start && req_i.write && hit && wr_ok;
  assign ack_o  = req_i.start && hit;
  assign nack_o = req_i.start && !hit;

  // ****************************************************************
  // Register updates
  // ****************************************************************
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tbl_sel_ff <= `AMLT_TBL_LUT0;
    end else if (do_wr && bank == 2'h0 && req_i.loc == `AMLT_TBL_SEL_LOC) begin
      tbl_sel_ff <= req_i.wdata; // [RULE13]
    end
  end

  logic tbl1_wr;
  assign tbl1_wr = do_wr && is_main && req_i.loc[7] && (tbl_sel_ff == `AMLT_TBL_LUT0);

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cfg_ff     <= `AMLT_CFG_RESET;
      nv_addr_ff <= `AMLT_MAIN_DEV_ADDR;
      man0_ff    <= `AMLT_MEM_RESET;
      man1_ff    <= `AMLT_MEM_RESET;
    end else if (tbl1_wr) begin
      if (req_i.loc == `AMLT_CFG_LOC) begin
        cfg_ff <= req_i.wdata;
      end else if (req_i.loc == `AMLT_NV_ADDR_LOC) begin
        nv_addr_ff <= req_i.wdata; // [RULE10]
      end else if (req_i.loc == `AMLT_MAN_R0_LOC) begin
        man0_ff <= req_i.wdata; // [RULE5]
      end else if (req_i.loc == `AMLT_MAN_R1_LOC) begin
        man1_ff <= req_i.wdata; // [RULE5]
      end
    end
  end

  // ****************************************************************
  // Memory ports: bus access wins; look-up reads fill idle cycles
  // ****************************************************************
  logic [9:0] waddr;
  logic [9:0] raddr;
  logic [7:0] mem_rdata;
  logic [7:0] lut_loc;
  amlt_state_t state_ff;
  logic [1:0] lut_phase_ff;
  logic       bus_rd;

  assign lut_loc = lut_index(meas_i.temp);
  assign bus_rd  = req_i.start && !req_i.write && hit;
  assign waddr   = mem_addr(bank, (bank == 2'h3) ? aux_loc : req_i.loc);

  always_comb begin
    if (bus_rd) begin
      raddr = mem_addr(bank, (bank == 2'h3) ? aux_loc : req_i.loc);
    end else begin
      // Bank 1 holds resistor 0, bank 2 resistor 1, same location
      raddr = mem_addr(lut_phase_ff[0] ? 2'h2 : 2'h1, lut_loc); // [RULE3]
    end
  end

  amlt_mem #(
    .AW(MEM_AW)
  ) u_mem (
    .core_clk_i (core_clk_i),
    .we_i       (do_wr),
    .waddr_i    (waddr),
    .wdata_i    (req_i.wdata),
    .raddr_i    (raddr),
    .rdata_o    (mem_rdata)
  );

  // Measured words read live; low four bits forced to zero
  logic [7:0] meas_byte_ff;
  logic       meas_sel_ff;
  logic [15:0] meas_word;
  always_comb begin
    case (req_i.loc[3:1])
      3'h0:    meas_word = meas_i.temp & mask_cfg; // [RULE6] [RULE19]
      3'h1:    meas_word = meas_i.vcc & mask_cfg; // [RULE7] [RULE19]
      3'h2:    meas_word = meas_i.mon_a & mask_cfg; // [RULE8]
      3'h3:    meas_word = meas_i.mon_b & mask_cfg; // [RULE8]
      default: meas_word = meas_i.mon_c & mask_cfg; // [RULE8]
    endcase
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meas_byte_ff <= 8'h00;
      meas_sel_ff  <= 1'b0;
    end else begin
      meas_sel_ff  <= bus_rd && meas_hit;
      meas_byte_ff <= req_i.loc[0] ? meas_word[7:0] : meas_word[15:8];
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_ff <= AMLT_IDLE;
      rvalid_o <= 1'b0;
      rdata_o  <= 8'h00;
    end else begin
      case (state_ff)
        AMLT_IDLE: begin
          rvalid_o <= 1'b0;
          if (bus_rd) begin
            state_ff <= AMLT_READ;
          end
        end
        AMLT_READ: begin
          rvalid_o <= 1'b1;
          rdata_o  <= meas_sel_ff ? meas_byte_ff : mem_rdata;
          state_ff <= AMLT_DONE;
        end
        default: begin
          rvalid_o <= 1'b0;
          state_ff <= AMLT_IDLE;
        end
      endcase
    end
  end

  // ****************************************************************
  // Resistor positions: refresh one resistor per free cycle
  // ****************************************************************
  logic lut_rd_ff;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      lut_phase_ff <= 2'h0;
      lut_rd_ff    <= 1'b0;
    end else begin
      lut_rd_ff <= !bus_rd;
      if (!bus_rd) begin
        lut_phase_ff <= lut_phase_ff + 2'h1;
      end
    end
  end

  logic [7:0] lut0_ff;
  logic [7:0] lut1_ff;
  logic       last_phase_ff;
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      last_phase_ff <= 1'b0;
      lut0_ff       <= 8'h00;
      lut1_ff       <= 8'h00;
    end else begin
      last_phase_ff <= lut_phase_ff[0];
      if (lut_rd_ff && !last_phase_ff) begin
        lut0_ff <= mem_rdata; // [RULE3]
      end
      if (lut_rd_ff && last_phase_ff) begin
        lut1_ff <= mem_rdata; // [RULE3]
      end
    end
  end

  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      res0_pos_o <= 8'h00;
      res1_pos_o <= 8'h00;
    end else begin
      res0_pos_o <= temp_index_enable ? lut0_ff : man0_ff; // [RULE4] [RULE5]
      res1_pos_o <= temp_index_enable ? lut1_ff : man1_ff; // [RULE4] [RULE5]
    end
  end
endmodule : amlt_top

// File: common/amlt_params.svh
// Constants for the address map and resistor look-up block
`ifndef AMLT_PARAMS_SVH
`define AMLT_PARAMS_SVH
`define AMLT_AUX_DEV_ADDR    8'hA0
`define AMLT_MAIN_DEV_ADDR   8'hA2
`define AMLT_TBL_SEL_LOC     8'h7F
`define AMLT_LUT_FIRST       8'h80
`define AMLT_LUT_LAST        8'hC7
`define AMLT_MAN_R0_LOC      8'h82
`define AMLT_MAN_R1_LOC      8'h83
`define AMLT_NV_ADDR_LOC     8'h8C
`define AMLT_CFG_LOC         8'h89
`define AMLT_CFG_TEN_BIT     0
`define AMLT_CFG_SINGLE_ADDRESS_ENABLE_BIT    1
`define AMLT_CFG_MAIN_ADDRESS_FROM_NV_BIT   2
`define AMLT_CFG_MAIN_PROTECT_ENABLE_BIT    3
`define AMLT_CFG_AUX_PROTECT_ENABLE_BIT    4
`define AMLT_CFG_RESET       8'h01
`define AMLT_TEMP_LOC        8'h60
`define AMLT_VCC_LOC         8'h62
`define AMLT_MONA_LOC        8'h64
`define AMLT_MONB_LOC        8'h66
`define AMLT_MONC_LOC        8'h68
`define AMLT_TBL_AUX         8'h00
`define AMLT_TBL_LUT0        8'h01
`define AMLT_TBL_LUT1        8'h02
`define AMLT_TBL_MAP_AUX     8'h03
`define AMLT_TEMP_OFFSET     16'sd40
`define AMLT_MEAS_MASK       16'hFFF0
`define AMLT_MEM_RESET       8'h00
`endif

// File: common/amlt_pkg.sv
// Types for the address map and resistor look-up block
package amlt_pkg;
  typedef struct packed {
    logic       start;
    logic       write;
    logic [7:0] dev_addr;
    logic [7:0] loc;
    logic [7:0] wdata;
  } amlt_req_t;

  typedef struct packed {
    logic [15:0] temp;
    logic [15:0] vcc;
    logic [15:0] mon_a;
    logic [15:0] mon_b;
    logic [15:0] mon_c;
  } amlt_meas_t;

  typedef enum logic [1:0] {
    AMLT_BANK_NONE,
    AMLT_BANK_LOWER,
    AMLT_BANK_UPPER,
    AMLT_BANK_AUX
  } amlt_bank_t;

  typedef enum logic [1:0] {
    AMLT_IDLE,
    AMLT_READ,
    AMLT_DONE
  } amlt_state_t;
endpackage : amlt_pkg

// File: verilog/amlt_mem.sv
// Byte memory with registered read data
`timescale 1ns/1ps
`include "amlt_params.svh"
module amlt_mem #(
  parameter int AW = 9
) (
  input  wire logic          core_clk_i,
  input  wire logic          we_i,
  input  wire logic [AW-1:0] waddr_i,
  input  wire logic [7:0]    wdata_i,
  input  wire logic [AW-1:0] raddr_i,
  output logic      [7:0]    rdata_o
);
  // Factory content zero; nonvolatility is modelled by no reset
  logic [7:0] mem_q [0:(1<<AW)-1];

  initial begin
    for (int i = 0; i < (1<<AW); i++) begin
      mem_q[i] = `AMLT_MEM_RESET;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (we_i) begin
      mem_q[waddr_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i) begin
    rdata_o <= mem_q[raddr_i];
  end
endmodule : amlt_mem

// File: dv/amlt_top_asserts.sv
// Port checker for the address map block
`timescale 1ns/1ps
// ****
// Port checks
// ****
module amlt_top_asserts
  import amlt_pkg::*;
(
  input wire logic       core_clk_i,
  input wire logic       reset_n_i,
  input wire amlt_req_t  req_i,
  input wire amlt_meas_t meas_i,
  input wire logic       ack_o,
  input wire logic       nack_o,
  input wire logic       rvalid_o,
  input wire logic [7:0] rdata_o,
  input wire logic [7:0] main_addr_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence rd_go;
    req_i.start && !req_i.write && ack_o;
  endsequence
  sequence rd_temp;
    rd_go ##0 req_i.dev_addr == main_addr_o && req_i.loc == 8'h60;
  endsequence
  sequence aux_up;
    req_i.start && req_i.dev_addr == 8'hA0 && req_i.loc[7];
  endsequence
  ans_one_a: assert property (req_i.start |-> ack_o ^ nack_o)
    else $error("start without single answer");
  idle_quiet_a: assert property (!req_i.start |-> !(ack_o || nack_o))
    else $error("answer without start");
  aux_upper_a: assert property (aux_up |-> nack_o)
    else $error("aux reached upper memory");
  stray_dev_a: assert property (req_i.start && req_i.dev_addr != 8'hA0
    && req_i.dev_addr != main_addr_o |-> nack_o) else $error("foreign address taken");
  rd_lat_a: assert property (rd_go |-> ##1 !rvalid_o ##1 rvalid_o)
    else $error("read data late or early");
  rv_pulse_a: assert property (rvalid_o |=> !rvalid_o)
    else $error("read valid too long");
  rd_hold_a: assert property (!rvalid_o |-> $stable(rdata_o))
    else $error("read data moved");
  temp_hi_a: assert property (rd_temp |-> ##2 rdata_o == meas_i.temp[15:8])
    else $error("temperature byte wrong");
endmodule : amlt_top_asserts
bind amlt_top amlt_top_asserts u_chk (
  .core_clk_i(core_clk_i), .reset_n_i(reset_n_i), .req_i(req_i), .meas_i(meas_i),
  .ack_o(ack_o), .nack_o(nack_o), .rvalid_o(rvalid_o), .rdata_o(rdata_o),
  .main_addr_o(main_addr_o));

// File: dv/amlt_host.sv
// Bus host model issuing block requests
`timescale 1ns/1ps
// ****
// Host
// ****
module amlt_host
  import amlt_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       ack_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output amlt_req_t       req_o
);
  initial req_o = '0;
  // Fields inverted on release so stale values never pass for valid
  task automatic xfer(input logic w, input logic [7:0] d, l, v,
                      output logic a, output logic [7:0] r);
    @(posedge core_clk_i);
    #1 req_o = '{1'h1, w, d, l, v};
    #1 a = ack_i;
    @(posedge core_clk_i);
    #1 req_o = {1'h0, ~req_o[24:0]};
    r = 8'hXX;
    if (!w) begin
      @(posedge core_clk_i);
      #1 if (rvalid_i === 1'h1) r = rdata_i;
    end
  endtask : xfer
endmodule : amlt_host

// File: dv/tb_addr_map_and_resistor_lut.sv
// Self-checking bench for the address map block
`timescale 1ns/1ps
// ****
// Bench
// ****
module tb_addr_map_and_resistor_lut import amlt_pkg::*;;
  localparam logic [7:0] mn = 8'hA2;
  localparam logic [7:0] ax = 8'hA0;
  logic       clk, rst_n, wp, ack, nack, rv, a;
  logic [7:0] rdat, res0, res1, maddr, rd;
  amlt_req_t  req;
  amlt_meas_t meas;
  int         mismatches, samples_checked, cycles, k;
  int         temps[8] = '{-50, -40, -39, -38, 101, 102, 103, 120};
  amlt_top uut (.core_clk_i(clk), .reset_n_i(rst_n), .req_i(req), .meas_i(meas),
    .write_protect_pin_i(wp), .ack_o(ack), .nack_o(nack), .rvalid_o(rv), .rdata_o(rdat),
    .res0_pos_o(res0), .res1_pos_o(res1), .main_addr_o(maddr));
  amlt_host host (.core_clk_i(clk), .ack_i(ack), .rvalid_i(rv), .rdata_i(rdat),
    .req_o(req));
  initial begin
    clk = 1'h0;
    forever #25 clk = ~clk;
  end
  // Ceiling well above the roughly 600 cycles the run needs
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      mismatches++;
      wrap_up();
    end
  end
  task automatic chk(input logic [7:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
    end
  endtask : chk
  task automatic go(input logic w, input logic [7:0] d, l, v, input logic ea);
    host.xfer(w, d, l, v, a, rd);
    chk({7'h00, a}, {7'h00, ea});
  endtask : go
  task automatic wr(input logic [7:0] d, l, v);
    go(1'h1, d, l, v, 1'h1);
  endtask : wr
  task automatic rr(input logic [7:0] d, l, e);
    go(1'h0, d, l, 8'h00, 1'h1);
    chk(rd, e);
  endtask : rr
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    rst_n = 1'h0;
    wp = 1'h0;
    meas = {16'hD80F, 16'h8080, 16'hC000, 16'h1234, 16'hFFF8};
    repeat (12) @(posedge clk);
    #1 rst_n = 1'h1;
    chk(maddr, mn);
    // Config shadow resets on its own; the array byte keeps its factory zero
    rr(mn, 8'h89, 8'h00);
    rr(ax, 8'h05, 8'h00);
    wr(ax, 8'h05, 8'h5A);
    rr(ax, 8'h05, 8'h5A);
    go(1'h0, ax, 8'h80, 8'h00, 1'h0);
    go(1'h0, 8'hA4, 8'h00, 8'h00, 1'h0);
    for (int i = 0; i < 5; i++) begin
      rr(mn, 8'(8'h60 + 2 * i), meas[79 - 16 * i -: 8]);
      rr(mn, 8'(8'h61 + 2 * i), meas[71 - 16 * i -: 8] & 8'hF0);
    end
    // Fill both tables; the config byte sits inside table 01 and is restored after
    for (int t = 1; t < 3; t++) begin
      wr(mn, 8'h7F, 8'(t));
      for (int i = 0; i < 72; i++)
        wr(mn, 8'(8'h80 + i), t == 1 ? 8'(i * 3) : 8'(255 - i * 3));
    end
    wr(mn, 8'h7F, 8'h01);
    wr(mn, 8'h89, 8'h01);
    foreach (temps[j]) begin
      meas.temp = {8'(temps[j]), 8'h00};
      repeat (20) @(posedge clk);
      k = (temps[j] + 40) / 2;
      k = k < 0 ? 0 : (k > 71 ? 71 : k);
      chk(res0, 8'(k * 3));
      chk(res1, 8'(255 - k * 3));
    end
    wr(mn, 8'h89, 8'h00);
    wr(mn, 8'h82, 8'h33);
    wr(mn, 8'h83, 8'hCC);
    repeat (20) @(posedge clk);
    chk(res0, 8'h33);
    chk(res1, 8'hCC);
    wr(mn, 8'h8C, 8'hB0);
    wr(mn, 8'h89, 8'h04);
    chk(maddr, 8'hB0);
    rr(8'hB0, 8'h89, 8'h04);
    go(1'h0, mn, 8'h89, 8'h00, 1'h0);
    wr(8'hB0, 8'h89, 8'h02);
    go(1'h0, ax, 8'h05, 8'h00, 1'h0);
    wr(mn, 8'h7F, 8'h00);
    rr(mn, 8'h85, 8'h5A);
    wr(mn, 8'h7F, 8'h01);
    wr(mn, 8'h89, 8'h00);
    wr(mn, 8'h7F, 8'h03);
    rr(mn, 8'h85, 8'h5A);
    wr(mn, 8'h7F, 8'h00);
    go(1'h0, mn, 8'h85, 8'h00, 1'h0);
    wr(mn, 8'h7F, 8'h05);
    go(1'h0, mn, 8'h85, 8'h00, 1'h0);
    wr(mn, 8'h7F, 8'h01);
    wr(mn, 8'h89, 8'h08);
    wp = 1'h1;
    wr(mn, 8'h38, 8'h11);
    rr(mn, 8'h38, 8'h00);
    wp = 1'h0;
    wr(mn, 8'h38, 8'h11);
    rr(mn, 8'h38, 8'h11);
    wr(mn, 8'h89, 8'h10);
    wp = 1'h1;
    wr(mn, 8'h38, 8'h22);
    rr(mn, 8'h38, 8'h22);
    wr(ax, 8'h06, 8'h77);
    rr(ax, 8'h06, 8'h00);
    wrap_up();
  end
endmodule : tb_addr_map_and_resistor_lut
